/* pkg/vfcgp_pkg.sv */
// shared constants for the gated pulse counter around a synchronous v-to-f converter
package vfcgp_pkg;
    localparam int          STAGES_DEF     = 14;
    localparam int          RES_BITS_DEF   = 12;
    localparam int          SRC_DIV_DEF    = 8;
    localparam int          CHOP_DIV_DEF   = 8;
    localparam int          CORE_CLK_HZ    = 50000000;
    localparam int          FIRST_TAP      = 1;
    localparam int          SYNC_STAGES    = 2;
    localparam int          SLOPE_SHIFT    = 2;
    localparam logic [0:0]  RST_LEVEL      = 1'h0;
    localparam logic [1:0]  SLOPE_FLAT     = 2'h0;
    localparam logic [1:0]  SLOPE_RISE     = 2'h1;
    localparam logic [1:0]  SLOPE_FALL     = 2'h2;
    typedef enum logic [2:0] {
        VFCGP_IDLE  = 3'h1,
        VFCGP_GATE  = 3'h2,
        VFCGP_DONE  = 3'h4
    } vfcgp_state_t;
endpackage

/* hw/vfcgp_divider.sv */
// binary divider chain with master reset, stage taps exposed
`timescale 1ns/1ns
module vfcgp_divider #(
    parameter int STAGES = vfcgp_pkg::STAGES_DEF
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              tick,
    input  wire logic              master_reset,
    output logic [STAGES-1:0]      taps
);
    import vfcgp_pkg::*;

    initial begin
        if (STAGES < 2) $error("divider needs at least two stages");
    end

    logic [STAGES-1:0] next_taps;

    // synchronous equivalent of a ripple chain: stage k toggles at f/2^(k+1)
    assign next_taps = master_reset ? '0 :
                       (tick ? taps + STAGES'(1) : taps);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            taps <= '0;
        end else begin
            taps <= next_taps;
        end
    end
endmodule

/* hw/vfcgp_top.sv */
// gated pulse counter: converter clock, gate divider, chopper and counting
`timescale 1ns/1ns
module vfcgp_top #(
    parameter int STAGES   = vfcgp_pkg::STAGES_DEF,
    parameter int RES_BITS = vfcgp_pkg::RES_BITS_DEF,
    parameter int SRC_DIV  = vfcgp_pkg::SRC_DIV_DEF,
    parameter int CHOP_DIV = vfcgp_pkg::CHOP_DIV_DEF
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                enable,
    input  wire logic                pulse_in,
    input  wire logic                chop_src,
    output logic                     conv_clk,
    output logic                     chop_a,
    output logic                     chop_b,
    output logic [RES_BITS:0]        result,
    output logic                     result_ready,
    output logic [1:0]               slope,
    output logic                     gate_active
);
    import vfcgp_pkg::*;

    initial begin
        if (RES_BITS + 1 > STAGES) $error("RES_BITS too large for STAGES");
        if (RES_BITS < 2) $error("RES_BITS must be at least 2");
        if (SRC_DIV < 2 || SRC_DIV % 2 != 0) $error("SRC_DIV even, >= 2");
    end

    localparam int HALF = SRC_DIV / 2;
    localparam int HW   = (HALF > 1) ? $clog2(HALF) : 1;

    // converter clock: core_clk divided by SRC_DIV, 50% duty
    // SRC_DIV sets the gate time, pick it for whole line periods
    logic [HW-1:0]  src_cnt;
    logic           src_wrap;
    logic           conv_rise;
    assign src_wrap  = (src_cnt == HW'(HALF - 1));
    assign conv_rise = src_wrap && !conv_clk;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_cnt  <= '0;
            conv_clk <= 1'b0;
        end else begin
            src_cnt  <= src_wrap ? '0 : src_cnt + HW'(1);
            if (src_wrap) conv_clk <= !conv_clk;
        end
    end

    // gate divider counts converter clock periods
    logic [STAGES-1:0] taps;
    logic              div_clr;
    vfcgp_divider #(.STAGES(STAGES)) u_div (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .tick         (conv_rise),
        .master_reset (div_clr),
        .taps         (taps)
    );

    // low RES_BITS+1 stages all ones on a tick: 2N periods done
    logic gate_end;
    assign gate_end = conv_rise && (&taps[RES_BITS:0]);

    // pulse input synchroniser and register
    logic [SYNC_STAGES-1:0] pulse_sync;
    logic                   pulse_q;
    logic                   pulse_edge;
    assign pulse_edge = pulse_sync[SYNC_STAGES-1] && !pulse_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_sync <= '0;
            pulse_q    <= 1'b0;
        end else begin
            pulse_sync <= {pulse_sync[SYNC_STAGES-2:0], pulse_in};
            pulse_q    <= pulse_sync[SYNC_STAGES-1];
        end
    end

    // gate control
    vfcgp_state_t state;
    vfcgp_state_t next_state;
    logic [RES_BITS:0] pulse_cnt;
    logic [RES_BITS:0] next_cnt;

    always_comb begin
        next_state = state;
        unique case (state)
            VFCGP_IDLE: if (enable && conv_rise) next_state = VFCGP_GATE;
            VFCGP_GATE: if (gate_end) next_state = VFCGP_DONE;
            VFCGP_DONE: next_state = enable ? VFCGP_GATE : VFCGP_IDLE;
            default:    next_state = VFCGP_IDLE;
        endcase
    end

    // divider held clear outside a gate so every gate counts the same 2N converter ticks
    assign div_clr = (state != VFCGP_GATE);
    assign gate_active = (state == VFCGP_GATE);

    // saturate at all-ones count 2^(RES_BITS+1)-1
    assign next_cnt = (state != VFCGP_GATE) ? '0 :
                      (pulse_edge && !(&pulse_cnt)) ?
                      pulse_cnt + (RES_BITS+1)'(1) : pulse_cnt;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= VFCGP_IDLE;
            pulse_cnt  <= '0;
        end else begin
            state      <= next_state;
            pulse_cnt  <= next_cnt;
        end
    end

    // capture result at gate end, pulse ready one cycle
    logic [RES_BITS:0] final_cnt;
    assign final_cnt = pulse_edge && !(&pulse_cnt) ?
                       pulse_cnt + (RES_BITS+1)'(1) : pulse_cnt;

    // delta interpretation: full scale N, quarter-clock rate is N/2
    localparam logic [RES_BITS:0] MID = (RES_BITS+1)'(1) << (RES_BITS - 1);
    logic [1:0] next_slope;
    assign next_slope = (final_cnt > MID) ? SLOPE_RISE :
                        (final_cnt < MID) ? SLOPE_FALL : SLOPE_FLAT;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            result       <= '0;
            result_ready <= 1'b0;
            slope        <= SLOPE_FLAT;
        end else begin
            result_ready <= (state == VFCGP_GATE) && gate_end;
            if ((state == VFCGP_GATE) && gate_end) begin
                result <= final_cnt;
                slope  <= next_slope;
            end
        end
    end

    // chopper: source synchronised, toggled on each rising edge
    logic [SYNC_STAGES-1:0] chop_sync;
    logic                   chop_prev;
    logic                   chop_rise;
    assign chop_rise = chop_sync[SYNC_STAGES-1] && !chop_prev;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chop_sync <= '0;
            chop_prev <= 1'b0;
            chop_a    <= 1'b0;
            chop_b    <= 1'b1;
        end else begin
            chop_sync <= {chop_sync[SYNC_STAGES-2:0], chop_src};
            chop_prev <= chop_sync[SYNC_STAGES-1];
            if (chop_rise) begin
                chop_a <= !chop_a;
                chop_b <= chop_a;
            end
        end
    end
endmodule

/* bench/vfcgp_asserts.sv */
// port assertions for the gated pulse counter
`timescale 1ns/1ns
module vfcgp_asserts #(
    parameter int RES_BITS = 3,
    parameter int SRC_DIV  = 2
) (
    input wire logic              core_clk,
    input wire logic              rst_n,
    input wire logic              enable,
    input wire logic              chop_src,
    input wire logic              conv_clk,
    input wire logic              chop_a,
    input wire logic              chop_b,
    input wire logic [RES_BITS:0] result,
    input wire logic              result_ready,
    input wire logic [1:0]        slope,
    input wire logic              gate_active
);
    import vfcgp_pkg::*;
    localparam int GL = (2 ** (RES_BITS + 1)) * SRC_DIV;
    localparam logic [RES_BITS:0] MID = 2 ** (RES_BITS - 1);
    logic [3:0]  up;
    logic [15:0] gl;
    // up: cycles since reset release, held at 15, gl: length of the running gate
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            up <= 4'h0;
            gl <= 16'h0;
        end else begin
            up <= (up == 4'hF) ? up : up + 4'h1;
            gl <= gate_active ? gl + 16'h1 : 16'h0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chop_compl_a: assert property (chop_a != chop_b)
        else $error("chopper outputs not complementary");
    chop_cause_a: assert property (up > 4'h4 && $changed(chop_a)
        |-> $past(chop_src)) else $error("chopper moved without source");
    conv_half_a: assert property (up > 4'h4
        |-> conv_clk != $past(conv_clk, SRC_DIV / 2))
        else $error("converter clock not square");
    ready_end_a: assert property (up > 4'h2
        |-> result_ready == $fell(gate_active)) else $error("ready misplaced");
    gate_start_a: assert property ($rose(gate_active) |-> $past(enable))
        else $error("gate began without enable");
    gate_len_a: assert property ($fell(gate_active)
        |-> gl >= GL - 1 && gl <= GL + 1) else $error("gate length wrong");
    hold_res_a: assert property (up > 4'h2 && !result_ready
        |-> $stable(result) && $stable(slope)) else $error("result moved");
    slope_code_a: assert property (result_ready |-> slope ==
        (result == MID ? SLOPE_FLAT : result > MID ? SLOPE_RISE : SLOPE_FALL))
        else $error("slope code wrong");
    c_flat: cover property (result_ready && slope == SLOPE_FLAT);
    c_rise: cover property (result_ready && slope == SLOPE_RISE);
    c_fall: cover property (result_ready && slope == SLOPE_FALL);
endmodule

/* bench/vfcgp_conv_model.sv */
// converter model: one output pulse every period converter clocks
`timescale 1ns/1ns
module vfcgp_conv_model (
    input  wire logic       conv_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] period,
    output logic            pulse
);
    logic [3:0] cnt;
    logic       fire;
    // decision on the falling edge, shown on the next rising edge
    always @(negedge conv_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= 4'h0;
            fire <= 1'h0;
        end else begin
            cnt  <= (cnt + 4'h1 >= period) ? 4'h0 : cnt + 4'h1;
            fire <= period != 4'h0 && cnt == 4'h0;
        end
    end
    always @(posedge conv_clk or negedge rst_n) begin
        if (!rst_n) pulse <= 1'h0;
        else pulse <= fire;
    end
endmodule

/* bench/vfc_gated_pulse_counter_tb_top.sv */
// bench for the gated pulse counter
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module vfc_gated_pulse_counter_tb_top;
    import vfcgp_pkg::*;
    localparam int RB = 3;
    logic        core_clk, rst_n, enable, chop_src, pulse_in, conv_clk;
    logic        chop_a, chop_b, result_ready, gate_active;
    logic [RB:0] result;
    logic [1:0]  slope;
    logic [3:0]  period;
    int          err_count, n_checks;
    vfcgp_top #(.RES_BITS(RB), .SRC_DIV(2)) vfcgp_top_i (.*);
    vfcgp_conv_model vfcgp_conv_model_i (.conv_clk(conv_clk),
        .rst_n(rst_n), .period(period), .pulse(pulse_in));
    initial begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_ready();
        int i;
        i = 0;
        do @(negedge core_clk); while (result_ready !== 1'h1 && ++i < 200);
        `CHK(result_ready, 1'h1)
    endtask
    // count over a settled gate: 16 converter periods, 16/p pulses
    task automatic run_rate(input logic [3:0] p, input int exp);
        logic [1:0] want;
        period = p;
        wait_ready();
        wait_ready();
        `CHK(exp + 1 >= result && result + 1 >= exp, 1'h1)
        want = result == 4 ? SLOPE_FLAT : result > 4 ? SLOPE_RISE : SLOPE_FALL;
        `CHK(slope, want)
    endtask
    task automatic chop_test();
        int n, i;
        logic last;
        n = 0;
        last = chop_a;
        for (i = 0; i < 56; i++) begin
            @(negedge core_clk);
            chop_src = i < 48 && i % 12 < 6;
            n += chop_a !== last;
            last = chop_a;
        end
        `CHK(n, 4)
        `CHK(chop_b, ~chop_a)
    endtask
    task automatic stop_test();
        int i, seen;
        seen = 0;
        enable = 1'h0;
        repeat (40) @(negedge core_clk);
        for (i = 0; i < 80; i++) begin
            @(negedge core_clk);
            seen += result_ready !== 1'h0 || gate_active !== 1'h0;
        end
        `CHK(seen, 0)
    endtask
    initial begin
        #100000;
        err_count++;
        finish_test();
    end
    initial begin
        rst_n = 1'h0;
        enable = 1'h0;
        chop_src = 1'h0;
        period = 4'h0;
        err_count = 0;
        n_checks = 0;
        repeat (6) @(negedge core_clk);
        `CHK(result, 4'h0)
        `CHK(chop_b, 1'h1)
        rst_n = 1'h1;
        @(negedge core_clk);
        enable = 1'h1;
        run_rate(4'h2, 8);
        run_rate(4'h4, 4);
        run_rate(4'h8, 2);
        run_rate(4'h0, 0);
        chop_test();
        stop_test();
        finish_test();
    end
endmodule
bind vfcgp_top vfcgp_asserts #(.RES_BITS(RES_BITS), .SRC_DIV(SRC_DIV))
    vfcgp_asserts_i (.*);
